// File: hdl/sdc_bank_track.sv
// Purpose: Tracks which of the device banks hold an open row
// Assumes: Commands are one-cycle pulses from the controller
// Notes:   Auto precharge closes the bank when the burst is issued
`timescale 1ns/100ps
module sdc_bank_track #(
  parameter int unsigned NBANK = sdc_pkg::NBANK,
  parameter int unsigned BANK_W = sdc_pkg::BANK_W
) (
  input  wire logic              sys_clk_i,  // System clock
  input  wire logic              resetn_i,   // Async reset, active low
  input  wire logic              open_i,     // Activate issued
  input  wire logic              close_i,    // Single-bank close issued
  input  wire logic              close_all_i,// All banks closed
  input  wire logic [BANK_W-1:0] bank_i,     // Bank of the command
  output logic      [NBANK-1:0]  active_o    // One bit per open bank
);
  // Tracker state
  typedef struct packed {
    logic [NBANK-1:0] active;    // Open banks
  } sdc_bt_state_t;

  sdc_bt_state_t state;          // Registered state
  sdc_bt_state_t next_state;     // Next state

  // Update open set from issued commands
  always_comb begin
    next_state = state;
    if (close_all_i) begin
      next_state.active = '0;
    end else if (open_i) begin
      next_state.active[bank_i] = 1'b1;
    end else if (close_i) begin
      next_state.active[bank_i] = 1'b0;
    end
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign active_o = state.active;
endmodule

// File: hdl/sdc_ctrl.sv
// Purpose: Drives the command pins of a four-bank synchronous DRAM
// Assumes: Software issues orders over a simple strobe register port
// Notes:   Runs the power-up sequence itself, then accepts orders
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/100ps
// Operation
// R1: Device decodes commands at rising clock edge
// R2: Activate is cs, row low; col, write high
// R3: Write is cs, col, write low; precharge bit
// R4: Read is cs, col low; row, write high
// R5: Activate idle banks; access only active banks
// R6: Burst stop only during full-page burst
// R7: Mode set is all four strobes low
// R8: Device loads mode from address on edge
// R9: Clock enable qualified over two cycles
// R10: Refresh with enable high; self refresh low
// R11: Power down during burst becomes clock suspend
// R12: Hold no-operation while supplies ramp
// R13: Clock runs from power-up onward
// R14: Pause 200 us, then precharge all banks
// R15: Mask and clock enable high during pause
// R16: Mode set after all banks precharged
// R17: At least eight refreshes during initialization
// R18: Never rely on power-on mode contents
// R19: Mode holds length, order, latency, operating mode
// R20: Mode set before first activate
// R21: Mode set needs idle banks, enable high
// R22: No-operation right after mode set
// R23: Mask latency two on read, zero write
// R24: Device generates burst column addresses
// R25: Chip select high means deselect
// R26: Mask low enables data, high disables
module sdc_ctrl #(
  parameter int unsigned PAUSE_CYC = sdc_pkg::INIT_PAUSE_CYC
) (
  input  wire logic                        sys_clk_i,          // System clock
  input  wire logic                        resetn_i,           // Async reset, active low
  input  wire logic [3:0]                  reg_addr_i,         // Register index
  input  wire logic [15:0]                 reg_wdata_i,        // Write data
  input  wire logic                        reg_wr_i,           // Write strobe
  input  wire logic                        reg_rd_i,           // Read strobe
  output logic      [15:0]                 reg_rdata_o,        // Read data, next cycle
  output logic                             cs_n_o,             // Chip select, low
  output logic                             row_strobe_n_o,     // Row strobe, low
  output logic                             col_strobe_n_o,     // Column strobe, low
  output logic                             write_strobe_n_o,   // Write strobe, low
  output logic                             clk_en_o,           // Clock enable
  output logic                             lower_byte_mask_o,  // Lower byte mask
  output logic                             upper_byte_mask_o,  // Upper byte mask
  output logic                             bank_select_lo_o,   // Bank select bit 0
  output logic                             bank_select_hi_o,   // Bank select bit 1
  output logic      [sdc_pkg::ADDR_W-1:0]  addr_o              // Address pins
);
  // Controller phases, Gray coded in the listed order
  typedef enum logic [2:0] {
    SDC_PAUSE   = 3'b000,
    SDC_PREALL  = 3'b001,
    SDC_REFRESH = 3'b011,
    SDC_MODESET = 3'b010,
    SDC_READY   = 3'b110,
    SDC_WAIT    = 3'b111
  } sdc_phase_t;

  // Whole controller state
  typedef struct packed {
    sdc_phase_t                 phase;      // Current phase
    sdc_phase_t                 after;      // Phase after a gap
    logic [3:0]                 gap;        // Gap countdown
    logic [3:0]                 refreshes;  // Init refreshes done
    logic                       mode_ok;    // Mode register programmed
    logic                       init_done;  // Power-up finished
    logic                       busy;       // Order pending
    logic                       refused;    // Last order refused
    logic                       full_page;  // Full-page burst running
    logic [3:0]                 op;         // Pending order code
    logic [sdc_pkg::ADDR_W-1:0] op_addr;    // Pending address
    logic [1:0]                 op_bank;    // Pending bank
    logic [sdc_pkg::ADDR_W-1:0] mode;       // Mode value to program
    logic                       cke_req;    // Software clock enable
    logic [1:0]                 mask_req;   // Software byte masks
    logic [15:0]                rdata;      // Read data register
    logic [3:0]                 pins;       // cs,row,col,write levels
    logic                       cke;        // Clock enable pin
    logic [1:0]                 dqm;        // Byte mask pins
    logic [1:0]                 bank;       // Bank select pins
    logic [sdc_pkg::ADDR_W-1:0] addr;       // Address pins
  } sdc_state_t;

  sdc_state_t       state;          // Registered state
  sdc_state_t       next_state;     // Next state
  logic             pause_done;     // Pause elapsed
  logic [3:0]       bank_active;    // Open banks
  logic             trk_open;       // Activate issued
  logic             trk_close;      // Single precharge issued
  logic             trk_close_all;  // All-bank precharge issued
  logic [1:0]       trk_bank;       // Bank of issued command

  // Power-up pause counter
  sdc_pause_timer #(
    .PAUSE_CYC (PAUSE_CYC)
  ) u_pause (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .done_o    (pause_done)
  );

  // Open-bank tracker
  sdc_bank_track u_banks (
    .sys_clk_i   (sys_clk_i),
    .resetn_i    (resetn_i),
    .open_i      (trk_open),
    .close_i     (trk_close),
    .close_all_i (trk_close_all),
    .bank_i      (trk_bank),
    .active_o    (bank_active)
  );

  // Whether an order may go out now
  function automatic logic order_legal(input logic [3:0] op, input logic [3:0] act,
                                       input logic [1:0] bank, input logic mode_ok,
                                       input logic full_page, input logic cke);
    unique case (op)
      sdc_pkg::SDC_OP_ACT:     order_legal = mode_ok && !act[bank] && cke;   // see R5 R20
      sdc_pkg::SDC_OP_READ,
      sdc_pkg::SDC_OP_WRITE:   order_legal = act[bank] && cke;               // see R5
      sdc_pkg::SDC_OP_MODESET: order_legal = (act == 4'h0) && cke;           // see R21
      sdc_pkg::SDC_OP_REFRESH,
      sdc_pkg::SDC_OP_SELFREF: order_legal = (act == 4'h0) && cke;           // see R10
      sdc_pkg::SDC_OP_BSTOP:   order_legal = full_page;                      // see R6
      default:                 order_legal = cke;
    endcase
  endfunction

  // Tracker strobes from the command driven this cycle
  always_comb begin
    trk_open      = 1'b0;
    trk_close     = 1'b0;
    trk_close_all = 1'b0;
    trk_bank      = next_state.bank;
    if (next_state.pins == sdc_pkg::cmd_pins(sdc_pkg::SDC_OP_ACT)) begin
      trk_open = 1'b1;
    end else if (next_state.pins == sdc_pkg::cmd_pins(sdc_pkg::SDC_OP_PRE)) begin
      trk_close_all = next_state.addr[sdc_pkg::PRE_SEL_POS];
      trk_close     = !next_state.addr[sdc_pkg::PRE_SEL_POS];
    end else if (next_state.pins[1] == 1'b0 && next_state.pins[2] == 1'b0
                 && next_state.pins[3] == 1'b0 && next_state.pins[0] == 1'b0) begin
      trk_close_all = 1'b0;
    end else if (next_state.pins == sdc_pkg::cmd_pins(sdc_pkg::SDC_OP_READ)
                 || next_state.pins == sdc_pkg::cmd_pins(sdc_pkg::SDC_OP_WRITE)) begin
      trk_close = next_state.addr[sdc_pkg::PRE_SEL_POS];  // see R3 R4
    end
  end

  // Sequencer, order issue and register port
  always_comb begin
    next_state      = state;
    next_state.pins = sdc_pkg::cmd_pins(sdc_pkg::SDC_OP_NOP);  // see R12 R22 R25
    // Register writes
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        sdc_pkg::REG_CMD: begin
          if (!state.busy && state.init_done) begin
            next_state.busy = 1'b1;
            next_state.op   = reg_wdata_i[3:0];
          end
        end
        sdc_pkg::REG_ADDR: next_state.op_addr = reg_wdata_i[sdc_pkg::ADDR_W-1:0];
        sdc_pkg::REG_BANK: next_state.op_bank = reg_wdata_i[1:0];
        sdc_pkg::REG_MODE: next_state.mode    = reg_wdata_i[sdc_pkg::ADDR_W-1:0];  // see R19
        sdc_pkg::REG_CKE:  next_state.cke_req = reg_wdata_i[0];
        sdc_pkg::REG_MASK: next_state.mask_req = reg_wdata_i[1:0];  // see R26
        default: ;
      endcase
    end
    // Register reads, answered next cycle
    next_state.rdata = 16'h0000;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        sdc_pkg::REG_ADDR:   next_state.rdata = {3'h0, state.op_addr};
        sdc_pkg::REG_BANK:   next_state.rdata = {14'h0000, state.op_bank};
        sdc_pkg::REG_STATUS: next_state.rdata = {5'h00, state.phase, bank_active,
                                                 state.full_page, state.refused,
                                                 state.init_done, state.busy};
        sdc_pkg::REG_MODE:   next_state.rdata = {3'h0, state.mode};
        sdc_pkg::REG_CKE:    next_state.rdata = {15'h0000, state.cke_req};
        sdc_pkg::REG_MASK:   next_state.rdata = {14'h0000, state.mask_req};
        default:             next_state.rdata = 16'h0000;
      endcase
    end
    // Phase machine
    unique case (state.phase)
      SDC_PAUSE: begin
        next_state.cke = 1'b1;                    // see R15 R13
        next_state.dqm = 2'b11;                   // see R15
        if (pause_done) begin
          next_state.phase = SDC_PREALL;          // see R14
        end
      end
      SDC_PREALL: begin
        next_state.pins = sdc_pkg::cmd_pins(sdc_pkg::SDC_OP_PREALL);  // see R14
        next_state.addr[sdc_pkg::PRE_SEL_POS] = 1'b1;
        next_state.phase = SDC_WAIT;
        next_state.after = SDC_REFRESH;
        next_state.gap   = 4'(sdc_pkg::CMD_GAP_CYC);
      end
      SDC_REFRESH: begin
        next_state.pins      = sdc_pkg::cmd_pins(sdc_pkg::SDC_OP_REFRESH);  // see R17
        next_state.refreshes = state.refreshes + 4'h1;
        next_state.phase     = SDC_WAIT;
        next_state.gap       = 4'(sdc_pkg::CMD_GAP_CYC);
        next_state.after     = (state.refreshes + 4'h1 >= 4'(sdc_pkg::INIT_REFRESHES))
                               ? SDC_MODESET : SDC_REFRESH;
      end
      SDC_MODESET: begin
        next_state.pins    = sdc_pkg::cmd_pins(sdc_pkg::SDC_OP_MODESET);  // see R16 R18 R21
        next_state.addr    = state.mode;
        next_state.bank    = 2'b00;
        next_state.mode_ok = 1'b1;
        next_state.phase   = SDC_WAIT;
        next_state.after   = SDC_READY;
        next_state.gap     = 4'(sdc_pkg::CMD_GAP_CYC);
      end
      SDC_WAIT: begin
        if (state.gap <= 4'h1) begin               // see R22
          next_state.phase = state.after;
          if (state.after == SDC_READY) begin
            next_state.init_done = 1'b1;
            next_state.dqm       = state.mask_req;
          end
        end else begin
          next_state.gap = state.gap - 4'h1;
        end
      end
      SDC_READY: begin
        next_state.cke = state.cke_req;           // see R9 R11
        next_state.dqm = state.mask_req;          // see R23 R26
        if (state.busy) begin
          next_state.busy = 1'b0;
          if (order_legal(state.op, bank_active, state.op_bank, state.mode_ok,
                          state.full_page, state.cke)) begin
            next_state.refused = 1'b0;
            next_state.pins    = sdc_pkg::cmd_pins(sdc_pkg::sdc_op_t'(state.op));  // see R2 R3 R4 R7
            next_state.addr    = state.op_addr;
            next_state.bank    = state.op_bank;
            if (state.op == sdc_pkg::SDC_OP_PREALL) begin
              next_state.addr[sdc_pkg::PRE_SEL_POS] = 1'b1;
            end else if (state.op == sdc_pkg::SDC_OP_PRE) begin
              next_state.addr[sdc_pkg::PRE_SEL_POS] = 1'b0;
            end
            if (state.op == sdc_pkg::SDC_OP_MODESET) begin
              next_state.addr  = state.mode;      // see R8 R20
              next_state.phase = SDC_WAIT;
              next_state.after = SDC_READY;
              next_state.gap   = 4'h1;            // see R22
            end
            if (state.op == sdc_pkg::SDC_OP_SELFREF) begin
              next_state.cke     = 1'b0;          // see R10
              next_state.cke_req = 1'b0;
            end
            if (state.op == sdc_pkg::SDC_OP_READ || state.op == sdc_pkg::SDC_OP_WRITE) begin
              next_state.full_page = (state.mode[2:0] == 3'h7);  // see R24
            end
            if (state.op == sdc_pkg::SDC_OP_BSTOP || state.op == sdc_pkg::SDC_OP_PRE
                || state.op == sdc_pkg::SDC_OP_PREALL) begin
              next_state.full_page = 1'b0;
            end
          end else begin
            next_state.refused = 1'b1;
          end
        end
      end
      default: next_state.phase = SDC_PAUSE;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state       <= '0;
      state.mode  <= sdc_pkg::MODE_RESET;
      state.pins  <= 4'hF;
      state.cke   <= 1'b1;
      state.dqm   <= 2'b11;
      state.cke_req <= 1'b1;
      state.mask_req <= 2'b11;
      state.phase <= SDC_PAUSE;
      state.after <= SDC_PAUSE;
    end else begin
      state <= next_state;
    end
  end

  // Pins straight from flip-flops
  assign cs_n_o            = state.pins[3];  // see R1
  assign row_strobe_n_o    = state.pins[2];
  assign col_strobe_n_o    = state.pins[1];
  assign write_strobe_n_o  = state.pins[0];
  assign clk_en_o          = state.cke;
  assign lower_byte_mask_o = state.dqm[0];
  assign upper_byte_mask_o = state.dqm[1];
  assign bank_select_lo_o  = state.bank[0];
  assign bank_select_hi_o  = state.bank[1];
  assign addr_o            = state.addr;
  assign reg_rdata_o       = state.rdata;
endmodule

// File: hdl/sdc_pause_timer.sv
// Purpose: Counts the power-up pause and reports when it is over
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Count is a parameter so simulation can shorten it
`timescale 1ns/100ps
module sdc_pause_timer #(
  parameter int unsigned PAUSE_CYC = sdc_pkg::INIT_PAUSE_CYC
) (
  input  wire logic sys_clk_i,    // System clock
  input  wire logic resetn_i,     // Async reset, active low
  output logic      done_o        // High once the pause has elapsed
);
  // Counter state
  typedef struct packed {
    logic [31:0] count;           // Cycles elapsed
    logic        done;            // Pause over
  } sdc_pt_state_t;

  sdc_pt_state_t state;           // Registered state
  sdc_pt_state_t next_state;      // Next state

  // Count until the pause is reached, then hold
  always_comb begin
    next_state = state;
    if (!state.done) begin
      next_state.count = state.count + 32'h0000_0001;
      if (state.count + 32'h0000_0001 >= PAUSE_CYC) begin
        next_state.done = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign done_o = state.done;
endmodule

// File: hdl/sdc_pkg.sv
// Purpose: Shared constants for the synchronous DRAM command controller
// Assumes: 10 MHz system clock, four-bank device, 13-bit address
// Notes:   Mode field positions are ordinary choices, kept here once
package sdc_pkg;
  // Clock rate and initial pause
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned INIT_PAUSE_US   = 200;
  localparam int unsigned INIT_PAUSE_CYC  = (INIT_PAUSE_US * (CLK_HZ / 1_000_000));
  // Refresh count at initialization
  localparam int unsigned INIT_REFRESHES  = 8;
  // Gap cycles after the power-up precharge, refresh and mode set
  localparam int unsigned CMD_GAP_CYC     = 2;
  // Address widths
  localparam int unsigned ADDR_W          = 13;
  localparam int unsigned BANK_W          = 2;
  localparam int unsigned NBANK           = 4;
  // Column-address bit that selects auto or all precharge
  localparam int unsigned PRE_SEL_POS     = 10;
  // Mode register field positions
  localparam int unsigned MODE_BL_LSB     = 0;
  localparam int unsigned MODE_ORDER_POS  = 3;
  localparam int unsigned MODE_LAT_LSB    = 4;
  localparam int unsigned MODE_OPM_POS    = 9;
  // Software register offsets
  localparam logic [3:0] REG_CMD          = 4'h0;
  localparam logic [3:0] REG_ADDR         = 4'h1;
  localparam logic [3:0] REG_BANK         = 4'h2;
  localparam logic [3:0] REG_STATUS       = 4'h3;
  localparam logic [3:0] REG_MODE         = 4'h4;
  localparam logic [3:0] REG_CKE          = 4'h5;
  localparam logic [3:0] REG_MASK         = 4'h6;
  // Reset values
  localparam logic [12:0] MODE_RESET      = 13'h0_022;
  // Command codes written to REG_CMD
  typedef enum logic [3:0] {
    SDC_OP_NOP      = 4'h0,
    SDC_OP_ACT      = 4'h1,
    SDC_OP_READ     = 4'h2,
    SDC_OP_WRITE    = 4'h3,
    SDC_OP_PRE      = 4'h4,
    SDC_OP_PREALL   = 4'h5,
    SDC_OP_REFRESH  = 4'h6,
    SDC_OP_MODESET  = 4'h7,
    SDC_OP_BSTOP    = 4'h8,
    SDC_OP_SELFREF  = 4'h9,
    SDC_OP_DESELECT = 4'hA
  } sdc_op_t;
  // Pin levels for one command: cs, row, col, write strobes (active low)
  function automatic logic [3:0] cmd_pins(input sdc_op_t op);
    unique case (op)
      SDC_OP_ACT:      cmd_pins = 4'h3;
      SDC_OP_READ:     cmd_pins = 4'h5;
      SDC_OP_WRITE:    cmd_pins = 4'h4;
      SDC_OP_PRE:      cmd_pins = 4'h2;
      SDC_OP_PREALL:   cmd_pins = 4'h2;
      SDC_OP_REFRESH:  cmd_pins = 4'h1;
      SDC_OP_SELFREF:  cmd_pins = 4'h1;
      SDC_OP_MODESET:  cmd_pins = 4'h0;
      SDC_OP_BSTOP:    cmd_pins = 4'h6;
      SDC_OP_DESELECT: cmd_pins = 4'hF;
      default:         cmd_pins = 4'h7;
    endcase
  endfunction
endpackage

// File: tb/sdc_ctrl_monitor.sv
// Purpose: Port checker for the DRAM command controller
// Assumes: One clock, asynchronous active-low reset
// Notes:   Helper logic follows the power-up sequence
`timescale 1ns/100ps
module sdc_ctrl_monitor #(
  parameter int unsigned PAUSE_CYC = 20
) (
  input wire logic        sys_clk_i,          // System clock
  input wire logic        resetn_i,           // Reset, active low
  input wire logic        cs_n_o,             // Chip select
  input wire logic        row_strobe_n_o,     // Row strobe
  input wire logic        col_strobe_n_o,     // Column strobe
  input wire logic        write_strobe_n_o,   // Write strobe
  input wire logic        clk_en_o,           // Clock enable
  input wire logic        lower_byte_mask_o,  // Lower mask
  input wire logic        upper_byte_mask_o,  // Upper mask
  input wire logic [12:0] addr_o              // Address pins
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [3:0]  cmd;        // Strobes as one vector
  logic [15:0] cyc;        // Edges since reset release
  logic [3:0]  refs;       // Refreshes before mode set
  logic        mode_seen;  // Mode set issued
  logic        any_cmd;    // Some real command issued
  assign cmd = {cs_n_o, row_strobe_n_o, col_strobe_n_o, write_strobe_n_o};
  // Sequence tracking, restarted by every reset
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cyc <= 16'h0000;
      refs <= 4'h0;
      mode_seen <= 1'b0;
      any_cmd <= 1'b0;
    end else begin
      cyc <= (cyc == 16'hFFFF) ? cyc : cyc + 16'h0001;
      refs <= (cmd == 4'h1 && !mode_seen && refs != 4'hF) ? refs + 4'h1 : refs;
      mode_seen <= mode_seen | (cmd == 4'h0);
      any_cmd <= any_cmd | (cmd != 4'h7 && cmd != 4'hF);
    end
  end
  a_pause_levels: assert property (cyc < PAUSE_CYC |->
    clk_en_o && lower_byte_mask_o && upper_byte_mask_o)
    else $error("enable or mask low in pause");
  a_pause_idle: assert property (cyc < PAUSE_CYC |-> cmd == 4'h7 || cmd == 4'hF)
    else $error("command during pause");
  a_first_precharge: assert property (cmd != 4'h7 && cmd != 4'hF && !any_cmd |->
    cmd == 4'h2 && addr_o[10] && cyc >= PAUSE_CYC)
    else $error("first command not precharge all");
  a_cmd_pulse: assert property (cmd != 4'h7 && cmd != 4'hF && cmd != 4'h0 |=> cmd == 4'h7)
    else $error("command longer than one cycle");
  a_mode_gap: assert property (cmd == 4'h0 |=> cmd == 4'h7)
    else $error("no idle cycle after mode set");
  a_refresh_count: assert property (cmd == 4'h0 && !mode_seen |-> refs >= 4'h8)
    else $error("too few refreshes");
  a_act_after_mode: assert property (cmd == 4'h3 |-> mode_seen)
    else $error("activate before mode set");
  a_mode_cke: assert property (cmd == 4'h0 |-> clk_en_o && $past(clk_en_o))
    else $error("mode set with enable low");
  a_access_cke: assert property (cmd inside {4'h3, 4'h4, 4'h5} |-> $past(clk_en_o))
    else $error("access with enable low before");
  c_activate: cover property (cmd == 4'h3);
  c_mode_set: cover property (cmd == 4'h0 ##1 cmd == 4'h7);
  c_precharge: cover property (cmd == 4'h2);
endmodule
bind sdc_ctrl sdc_ctrl_monitor #(.PAUSE_CYC(PAUSE_CYC)) u_mon (.sys_clk_i(sys_clk_i),
  .resetn_i(resetn_i), .cs_n_o(cs_n_o), .row_strobe_n_o(row_strobe_n_o),
  .col_strobe_n_o(col_strobe_n_o), .write_strobe_n_o(write_strobe_n_o), .clk_en_o(clk_en_o),
  .lower_byte_mask_o(lower_byte_mask_o), .upper_byte_mask_o(upper_byte_mask_o), .addr_o(addr_o));

// File: tb/sdc_dev_model.sv
// Purpose: Behavioural model of the four-bank DRAM command decoder
// Assumes: Commands come as one-cycle pin levels
// Notes:   Counts illegal activate, access, mode set and refresh commands, and any command right after a mode set
`timescale 1ns/100ps
module sdc_dev_model (
  input  wire logic        sys_clk_i,  // Device clock
  input  wire logic [3:0]  cmd_i,      // Chip select, row, column, write
  input  wire logic        cke_i,      // Clock enable
  input  wire logic [1:0]  bank_i,     // Bank select
  input  wire logic [12:0] addr_i,     // Address
  output int               errs_o,     // Illegal commands seen
  output logic [12:0]      mode_o      // Mode register
);
  logic [3:0] open_q = 4'h0;  // Open banks
  logic       cke_q = 1'b1;   // Enable one edge back
  logic       mode_ok = 1'b0; // Mode programmed
  logic       mrs_q = 1'b0;   // Last command was mode set
  initial errs_o = 0;
  initial mode_o = 'x;  // Unknown until programmed
  // Decode at the rising edge
  always @(posedge sys_clk_i) begin
    cke_q <= cke_i;
    mrs_q <= 1'b0;
    if (!cmd_i[3] && cke_q) begin
      if (mrs_q && cmd_i != 4'h7) errs_o++;
      case (cmd_i[2:0])
        3'b011: begin
          if (open_q[bank_i] || !mode_ok) errs_o++;
          open_q[bank_i] <= 1'b1;
        end
        3'b101, 3'b100: begin
          if (!open_q[bank_i]) errs_o++;
          if (addr_i[10]) open_q[bank_i] <= 1'b0;
        end
        3'b010: if (addr_i[10]) open_q <= 4'h0; else open_q[bank_i] <= 1'b0;
        3'b000: begin
          if (|open_q) errs_o++;
          mode_o <= addr_i;
          mode_ok <= 1'b1;
          mrs_q <= 1'b1;
        end
        3'b001: if (|open_q) errs_o++;
        default: ;
      endcase
    end
  end
endmodule

// File: tb/tb_top.sv
// Purpose: Self-checking bench for the DRAM command controller
// Assumes: Shortened pause of 20 cycles
// Notes:   Orders go through the register port, the model judges pins
`timescale 1ns/100ps
module tb_top;
  logic        sys_clk_i = 0, resetn_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, rd_q;
  logic        cs_n, row_n, col_n, we_n, cke, lmask, umask, bs_lo, bs_hi;
  logic [12:0] addr_o, dev_mode, row, mval;
  logic [1:0]  bank;
  int          fails = 0, total_checks = 0, dev_errs, seed;
  sdc_ctrl #(.PAUSE_CYC(20)) i_sdc_ctrl (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cs_n_o(cs_n), .row_strobe_n_o(row_n),
    .col_strobe_n_o(col_n), .write_strobe_n_o(we_n), .clk_en_o(cke), .lower_byte_mask_o(lmask),
    .upper_byte_mask_o(umask), .bank_select_lo_o(bs_lo), .bank_select_hi_o(bs_hi),
    .addr_o(addr_o));
  sdc_dev_model i_sdc_dev_model (.sys_clk_i(sys_clk_i), .cmd_i({cs_n, row_n, col_n, we_n}),
    .cke_i(cke), .bank_i({bs_hi, bs_lo}), .addr_i(addr_o), .errs_o(dev_errs), .mode_o(dev_mode));
  initial begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 rd_q = reg_rdata_o;
  endtask
  // One order: pins in the issue cycle, then the refused flag
  task automatic issue(input logic [3:0] op, input logic [3:0] pins, input logic refused);
    wr(sdc_pkg::REG_CMD, {12'h000, op});
    @(posedge sys_clk_i);
    #1 chk({12'h000, cs_n, row_n, col_n, we_n}, {12'h000, pins});
    rd(sdc_pkg::REG_STATUS);
    chk({15'h0000, rd_q[2]}, {15'h0000, refused});
  endtask
  task automatic end_of_test;
    if (fails == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #300000;
    fails++;
    end_of_test;
  end
  initial begin
    seed = $urandom(33);
    repeat (5) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    rd(sdc_pkg::REG_CKE);
    chk(rd_q, 16'h0001);
    rd(sdc_pkg::REG_MASK);
    chk(rd_q, 16'h0003);
    #1 chk({13'h0000, cke, lmask, umask}, 16'h0007);
    for (int i = 0; i < 100 && (i == 0 || rd_q[1] !== 1'b1); i++) rd(sdc_pkg::REG_STATUS);
    chk({15'h0000, rd_q[1]}, 16'h0001);
    chk({3'h0, dev_mode}, 16'h0022);
    bank = 2'($urandom);
    row = 13'($urandom);
    wr(sdc_pkg::REG_ADDR, {3'h0, row});
    wr(sdc_pkg::REG_BANK, {14'h0000, bank});
    issue(sdc_pkg::SDC_OP_ACT, 4'h3, 1'b0);
    chk({1'b0, bs_hi, bs_lo, addr_o}, {1'b0, bank, row});
    issue(sdc_pkg::SDC_OP_ACT, 4'h7, 1'b1);
    wr(sdc_pkg::REG_ADDR, 16'h0000);
    issue(sdc_pkg::SDC_OP_READ, 4'h5, 1'b0);
    wr(sdc_pkg::REG_ADDR, 16'h0400);
    issue(sdc_pkg::SDC_OP_WRITE, 4'h4, 1'b0);
    issue(sdc_pkg::SDC_OP_READ, 4'h7, 1'b1);
    issue(sdc_pkg::SDC_OP_BSTOP, 4'h7, 1'b1);
    mval = 13'($urandom);
    wr(sdc_pkg::REG_MODE, {3'h0, mval});
    issue(sdc_pkg::SDC_OP_MODESET, 4'h0, 1'b0);
    chk({3'h0, dev_mode}, {3'h0, mval});
    issue(sdc_pkg::SDC_OP_REFRESH, 4'h1, 1'b0);
    issue(sdc_pkg::SDC_OP_DESELECT, 4'hF, 1'b0);
    issue(sdc_pkg::SDC_OP_PREALL, 4'h2, 1'b0);
    chk({15'h0000, addr_o[10]}, 16'h0001);
    issue(sdc_pkg::SDC_OP_NOP, 4'h7, 1'b0);
    issue(sdc_pkg::SDC_OP_SELFREF, 4'h1, 1'b0);
    chk({15'h0000, cke}, 16'h0000);
    issue(sdc_pkg::SDC_OP_REFRESH, 4'h7, 1'b1);
    chk(dev_errs[15:0], 16'h0000);
    end_of_test;
  end
endmodule
